/* design/addressing_mode_ea_unit.v */
// Purpose: Decode opcode stream into mode, length, operand address, branch
//          target and the unsigned multiply result
// Assumes: One fetch byte per cycle when fetch_valid is high; pc_in is the
//          address of the byte on fetch_byte while an opcode is presented
// Notes:   Results appear one cycle after the last byte of an instruction
`timescale 1ns/10ps
`include "addressing_mode_ea_unit_defines.vh"

// Operation
// - Every one of the 256 opcodes maps to one instruction and one of eight addressing modes.
// - The unsigned multiply forms accumulator times index, high byte to index, low byte to accumulator.
// - Inherent instructions are one byte long and form no operand address.
// - Immediate instructions are two bytes, the second byte is the operand and no address is formed.
// - Direct instructions are two bytes, the second byte is the low address with a zero high byte.
// - Extended instructions are three bytes carrying the high then the low address byte.
// - Indexed with no offset is one byte and uses the index register as a zero-page address.
// - Indexed with 8-bit offset is two bytes and adds index and offset with carry into the high byte.
// - Indexed with 16-bit offset is three bytes and adds the index to a high-first 16-bit offset.
// - Taken branches add the sign-extended offset to the address past the branch, else fall through.
module addressing_mode_ea_unit
#(
  parameter ADDR_W = 16
)
(
  clk,
  arst_n,
  fetch_valid,
  fetch_byte,
  pc_in,
  acc_in,
  idx_in,
  cond_true,
  dec_valid_ff,
  opcode_ff,
  mode_ff,
  length_ff,
  ea_valid_ff,
  ea_ff,
  imm_valid_ff,
  imm_ff,
  pc_next_ff,
  mul_valid_ff,
  mul_acc_ff,
  mul_idx_ff,
  busy
);
  input  wire              clk;
  input  wire              arst_n;
  input  wire              fetch_valid;
  input  wire [7:0]        fetch_byte;
  input  wire [ADDR_W-1:0] pc_in;
  input  wire [7:0]        acc_in;
  input  wire [7:0]        idx_in;
  input  wire              cond_true;
  output reg               dec_valid_ff;
  output reg  [7:0]        opcode_ff;
  output reg  [2:0]        mode_ff;
  output reg  [1:0]        length_ff;
  output reg               ea_valid_ff;
  output reg  [15:0]       ea_ff;
  output reg               imm_valid_ff;
  output reg  [7:0]        imm_ff;
  output reg  [15:0]       pc_next_ff;
  output reg               mul_valid_ff;
  output reg  [7:0]        mul_acc_ff;
  output reg  [7:0]        mul_idx_ff;
  output wire              busy;

  // ========================================================================
  // States, one-hot
  // ========================================================================
  localparam [2:0] S_OPC = 3'b001;
  localparam [2:0] S_OP1 = 3'b010;
  localparam [2:0] S_OP2 = 3'b100;

  // ========================================================================
  // Decode functions
  // ========================================================================
  // column decides the mode
  function [2:0] mode_of;
    input [7:0] opc;
    begin
      case (opc[`OPC_COL_HI:`OPC_COL_LO])
        `COL_BITTST:  mode_of = `MODE_DIR;
        `COL_BITSET:  mode_of = `MODE_DIR;
        `COL_BRANCH:  mode_of = `MODE_REL;
        `COL_RMW_DIR: mode_of = `MODE_DIR;
        `COL_INH_A:   mode_of = `MODE_INH;
        `COL_INH_X:   mode_of = `MODE_INH;
        `COL_RMW_IX1: mode_of = `MODE_IX1;
        `COL_RMW_IX:  mode_of = `MODE_IX;
        `COL_CTRL0:   mode_of = `MODE_INH;
        `COL_CTRL1:   mode_of = `MODE_INH;
        `COL_IMM:     mode_of = `MODE_IMM;
        `COL_DIR:     mode_of = `MODE_DIR;
        `COL_EXT:     mode_of = `MODE_EXT;
        `COL_IX2:     mode_of = `MODE_IX2;
        `COL_IX1:     mode_of = `MODE_IX1;
        default:      mode_of = `MODE_IX;
      endcase
    end
  endfunction

  // Byte count per mode
  function [1:0] len_of;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_INH: len_of = `LEN_1;
        `MODE_IX:  len_of = `LEN_1;
        `MODE_EXT: len_of = `LEN_3;
        `MODE_IX2: len_of = `LEN_3;
        default:   len_of = `LEN_2;
      endcase
    end
  endfunction

  // ========================================================================
  // State and captured bytes
  // ========================================================================
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [2:0]  cur_mode_ff;
  reg  [7:0]  cur_opc_ff;
  reg  [7:0]  hi_byte_ff;
  reg  [15:0] opc_addr_ff;

  // ========================================================================
  // Combinational decode of the current byte
  // ========================================================================
  wire [2:0]  opc_mode  = mode_of(fetch_byte);
  wire [2:0]  act_mode  = (state_ff == S_OPC) ? opc_mode : cur_mode_ff;
  wire [7:0]  act_opc   = (state_ff == S_OPC) ? fetch_byte : cur_opc_ff;
  wire [1:0]  act_len   = len_of(act_mode);
  wire [15:0] act_addr  = (state_ff == S_OPC) ? pc_in[15:0] : opc_addr_ff;
  wire        taking    = fetch_valid;
  reg         last_byte;
  reg  [7:0]  opr_hi;
  reg  [7:0]  opr_lo;

  // Address past the whole instruction
  wire [15:0] pc_seq    = act_addr + {14'h0000, act_len};

  // Last byte of the instruction and operand assembly
  always @*
  begin
    last_byte = 1'b0;
    opr_hi    = `ZERO8;
    opr_lo    = `ZERO8;
    case (state_ff)
      S_OPC:
      begin
        last_byte = (act_len == `LEN_1);
      end
      S_OP1:
      begin
        last_byte = (act_len == `LEN_2);
        opr_lo    = fetch_byte;
      end
      S_OP2:
      begin
        last_byte = 1'b1;
        opr_hi    = hi_byte_ff;
        opr_lo    = fetch_byte;
      end
      default:
      begin
        last_byte = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // Address arithmetic
  // ========================================================================
  wire [15:0] calc_ea;
  wire        calc_ea_used;
  wire [15:0] calc_pc;

  ea_calc u_ea_calc
  (
    .mode      (act_mode),
    .idx       (idx_in),
    .opr_hi    (opr_hi),
    .opr_lo    (opr_lo),
    .pc_seq    (pc_seq),
    .cond_true (cond_true),
    .ea        (calc_ea),
    .ea_used   (calc_ea_used),
    .pc_next   (calc_pc)
  );

  wire [15:0] product = {`ZERO8, acc_in} * {`ZERO8, idx_in};
  wire        is_umul = (act_opc == `OPC_UMUL);

  // ========================================================================
  // Next state
  // ========================================================================
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_OPC:
      begin
        if (taking && !last_byte)
          nxt_state = S_OP1;
      end
      S_OP1:
      begin
        if (taking)
          nxt_state = last_byte ? S_OPC : S_OP2;
      end
      S_OP2:
      begin
        if (taking)
          nxt_state = S_OPC;
      end
      default:
      begin
        nxt_state = S_OPC;
      end
    endcase
  end

  // Mid-instruction indicator for the fetch side
  assign busy = (state_ff != S_OPC);

  // ========================================================================
  // Sequencer registers
  // ========================================================================
  // Opcode context is held so later bytes decode against it
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff    <= S_OPC;
      cur_mode_ff <= `MODE_INH;
      cur_opc_ff  <= `ZERO8;
      hi_byte_ff  <= `ZERO8;
      opc_addr_ff <= `ZERO16;
    end
    else
    begin
      state_ff <= nxt_state;
      if (taking && (state_ff == S_OPC))
      begin
        cur_mode_ff <= opc_mode;
        cur_opc_ff  <= fetch_byte;
        opc_addr_ff <= pc_in[15:0];
      end
      if (taking && (state_ff == S_OP1))
        hi_byte_ff <= fetch_byte;
    end
  end

  // ========================================================================
  // Result registers
  // ========================================================================
  // Held until the next instruction completes; valid flags pulse once
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dec_valid_ff <= 1'b0;
      opcode_ff    <= `ZERO8;
      mode_ff      <= `MODE_INH;
      length_ff    <= `LEN_1;
      ea_valid_ff  <= 1'b0;
      ea_ff        <= `ZERO16;
      imm_valid_ff <= 1'b0;
      imm_ff       <= `ZERO8;
      pc_next_ff   <= `ZERO16;
      mul_valid_ff <= 1'b0;
      mul_acc_ff   <= `ZERO8;
      mul_idx_ff   <= `ZERO8;
    end
    else
    begin
      dec_valid_ff <= taking && last_byte;
      ea_valid_ff  <= 1'b0;
      imm_valid_ff <= 1'b0;
      mul_valid_ff <= 1'b0;
      if (taking && last_byte)
      begin
        opcode_ff   <= act_opc;
        mode_ff     <= act_mode;
        length_ff   <= act_len;
        ea_valid_ff <= calc_ea_used;
        ea_ff       <= calc_ea;
        pc_next_ff  <= calc_pc;
        if (act_mode == `MODE_IMM)
        begin
          imm_valid_ff <= 1'b1;
          imm_ff       <= opr_lo;
        end
        // high to index, low to accumulator
        if (is_umul)
        begin
          mul_valid_ff <= 1'b1;
          mul_idx_ff   <= product[15:8];
          mul_acc_ff   <= product[7:0];
        end
      end
    end
  end

endmodule

/* design/addressing_mode_ea_unit_defines.vh */
// Purpose: Shared constants for the operand-address and length decoder
// Assumes: Included by its bare name from every design file that needs it
// Notes:   Opcode column map and the multiply opcode are fixed here only
`ifndef ADDRESSING_MODE_EA_UNIT_DEFINES_VH
`define ADDRESSING_MODE_EA_UNIT_DEFINES_VH

// ==========================================================================
// Repertoire size
// ==========================================================================
`define NUM_INSNS      62
`define NUM_MODES      8

// ==========================================================================
// Addressing mode codes
// ==========================================================================
`define MODE_W         3
`define MODE_INH       3'h0
`define MODE_IMM       3'h1
`define MODE_DIR       3'h2
`define MODE_EXT       3'h3
`define MODE_IX        3'h4
`define MODE_IX1       3'h5
`define MODE_IX2       3'h6
`define MODE_REL       3'h7

// ==========================================================================
// Instruction lengths in bytes
// ==========================================================================
`define LEN_W          2
`define LEN_1          2'h1
`define LEN_2          2'h2
`define LEN_3          2'h3

// ==========================================================================
// Opcode high-nibble columns
// ==========================================================================
`define COL_BITTST     4'h0
`define COL_BITSET     4'h1
`define COL_BRANCH     4'h2
`define COL_RMW_DIR    4'h3
`define COL_INH_A      4'h4
`define COL_INH_X      4'h5
`define COL_RMW_IX1    4'h6
`define COL_RMW_IX     4'h7
`define COL_CTRL0      4'h8
`define COL_CTRL1      4'h9
`define COL_IMM        4'ha
`define COL_DIR        4'hb
`define COL_EXT        4'hc
`define COL_IX2        4'hd
`define COL_IX1        4'he
`define COL_IX         4'hf

// ==========================================================================
// Multiply opcode and field positions
// ==========================================================================
`define OPC_UMUL       8'h42
`define OPC_COL_HI     7
`define OPC_COL_LO     4

// ==========================================================================
// Reset values
// ==========================================================================
`define ZERO8          8'h00
`define ZERO16         16'h0000

`endif

/* design/ea_calc.v */
// Purpose: Effective address and next program counter for one instruction
// Assumes: Purely combinational, operands already assembled by the caller
// Notes:   Sums are cut to 16 bits, so large offsets wrap around memory
`timescale 1ns/10ps
`include "addressing_mode_ea_unit_defines.vh"

module ea_calc
(
  mode,
  idx,
  opr_hi,
  opr_lo,
  pc_seq,
  cond_true,
  ea,
  ea_used,
  pc_next
);
  input  wire [2:0]  mode;
  input  wire [7:0]  idx;
  input  wire [7:0]  opr_hi;
  input  wire [7:0]  opr_lo;
  input  wire [15:0] pc_seq;
  input  wire        cond_true;
  output reg  [15:0] ea;
  output reg         ea_used;
  output reg  [15:0] pc_next;

  // ========================================================================
  // Operand address per mode
  // ========================================================================
  always @*
  begin
    ea      = `ZERO16;
    ea_used = 1'b0;
    case (mode)
      `MODE_DIR:
      begin
        ea      = {`ZERO8, opr_lo};
        ea_used = 1'b1;
      end
      `MODE_EXT:
      begin
        ea      = {opr_hi, opr_lo};
        ea_used = 1'b1;
      end
      `MODE_IX:
      begin
        ea      = {`ZERO8, idx};
        ea_used = 1'b1;
      end
      `MODE_IX1:
      begin
        ea      = {`ZERO8, idx} + {`ZERO8, opr_lo};
        ea_used = 1'b1;
      end
      `MODE_IX2:
      begin
        ea      = {opr_hi, opr_lo} + {`ZERO8, idx};
        ea_used = 1'b1;
      end
      default:
      begin
        ea      = `ZERO16;
        ea_used = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // Branch target
  // ========================================================================
  // signed offset when taken
  always @*
  begin
    if ((mode == `MODE_REL) && cond_true)
      pc_next = pc_seq + {{8{opr_lo[7]}}, opr_lo};
    else
      pc_next = pc_seq;
  end

endmodule

/* test/addressing_mode_ea_unit_properties.sv */
// Purpose: Port-level checks for the operand address decoder
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Helper flops mirror what the decoder samples per byte
`timescale 1ns/10ps
module addressing_mode_ea_unit_properties
#(
  parameter ADDR_W = 16
)
(
  input logic              clk,
  input logic              arst_n,
  input logic              fetch_valid,
  input logic [7:0]        fetch_byte,
  input logic [ADDR_W-1:0] pc_in,
  input logic [7:0]        acc_in,
  input logic [7:0]        idx_in,
  input logic              cond_true,
  input logic              dec_valid_ff,
  input logic [7:0]        opcode_ff,
  input logic [2:0]        mode_ff,
  input logic [1:0]        length_ff,
  input logic              ea_valid_ff,
  input logic [15:0]       ea_ff,
  input logic              imm_valid_ff,
  input logic [7:0]        imm_ff,
  input logic [15:0]       pc_next_ff,
  input logic              mul_valid_ff,
  input logic [7:0]        mul_acc_ff,
  input logic [7:0]        mul_idx_ff,
  input logic              busy
);
  // ==========================================================
  // Helper state
  logic [7:0]        b1_ff, b2_ff, a_ff, x_ff;
  logic              c_ff;
  logic [ADDR_W-1:0] pc_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Last two bytes and operands; stalls do not disturb them
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      {b1_ff, b2_ff, a_ff, x_ff, c_ff, pc_ff} <= '0;
    else if (fetch_valid)
    begin
      {b2_ff, b1_ff} <= {b1_ff, fetch_byte};
      {a_ff, x_ff, c_ff} <= {acc_in, idx_in, cond_true};
      if (!busy)
        pc_ff <= pc_in;
    end

  // ==========================================================
  // Assertions
  AST_LEN: assert property (dec_valid_ff |-> length_ff == ((mode_ff == 3'h0 || mode_ff == 3'h4) ? 2'h1 :
    (mode_ff == 3'h3 || mode_ff == 3'h6) ? 2'h3 : 2'h2)) else $error("length does not fit mode");
  AST_INH: assert property (dec_valid_ff && mode_ff == 3'h0 |-> !ea_valid_ff && !imm_valid_ff
    && pc_next_ff == pc_ff + 16'h0001) else $error("inherent formed an operand");
  AST_ANS: assert property (fetch_valid && !busy && fetch_byte[7:4] == 4'h4
    |=> dec_valid_ff && mode_ff == 3'h0) else $error("one-byte answer late");
  AST_IMM: assert property (dec_valid_ff && mode_ff == 3'h1 |-> imm_valid_ff && imm_ff == $past(fetch_byte))
    else $error("immediate data wrong");
  AST_DIR: assert property (dec_valid_ff && mode_ff == 3'h2 |-> ea_valid_ff && ea_ff == {8'h00, $past(fetch_byte)})
    else $error("direct address wrong");
  AST_EXT: assert property (dec_valid_ff && mode_ff == 3'h3 |-> ea_valid_ff && ea_ff == {b2_ff, b1_ff})
    else $error("extended address wrong");
  AST_IX: assert property (dec_valid_ff && mode_ff == 3'h4 |-> ea_valid_ff && ea_ff == {8'h00, x_ff})
    else $error("indexed address wrong");
  AST_IX1: assert property (dec_valid_ff && mode_ff == 3'h5 |-> ea_ff == {8'h00, x_ff} + {8'h00, b1_ff})
    else $error("8-bit offset sum wrong");
  AST_IX2: assert property (dec_valid_ff && mode_ff == 3'h6 |-> ea_ff == {b2_ff, b1_ff} + {8'h00, x_ff})
    else $error("16-bit offset sum wrong");
  AST_REL: assert property (dec_valid_ff && mode_ff == 3'h7 |-> pc_next_ff == pc_ff + 16'h0002
    + (c_ff ? {{8{b1_ff[7]}}, b1_ff} : 16'h0000)) else $error("branch target wrong");
  AST_MUL: assert property (dec_valid_ff && opcode_ff == 8'h42 |-> mul_valid_ff
    && {mul_idx_ff, mul_acc_ff} == a_ff * x_ff) else $error("product wrong");

  // Main scenarios reached
  COV_TAKEN: cover property (dec_valid_ff && mode_ff == 3'h7 && c_ff);
  COV_MUL: cover property (mul_valid_ff);
  COV_IX2: cover property (dec_valid_ff && mode_ff == 3'h6);
endmodule

bind addressing_mode_ea_unit addressing_mode_ea_unit_properties #(.ADDR_W(ADDR_W)) chk_inst (.clk, .arst_n,
  .fetch_valid, .fetch_byte, .pc_in, .acc_in, .idx_in, .cond_true, .dec_valid_ff, .opcode_ff, .mode_ff,
  .length_ff, .ea_valid_ff, .ea_ff, .imm_valid_ff, .imm_ff, .pc_next_ff, .mul_valid_ff, .mul_acc_ff,
  .mul_idx_ff, .busy);

/* test/addressing_mode_ea_unit_tb.sv */
// Purpose: Self-checking bench for the operand address decoder
// Assumes: 40 MHz clock, inputs change 1 ns after the edge
// Notes:   Opcode address is always 1000 hex in table rows
`timescale 1ns/10ps
module addressing_mode_ea_unit_tb;
  // ==========================================================
  // Signals and table
  typedef struct {logic [7:0] op, b1, b2, a, x; logic c; logic [2:0] md; logic [1:0] ln; logic [15:0] ea, pn;} row_t;
  logic        clk, arst_n, go, stall, cond_true, fetch_valid, busy;
  logic        dec_valid_ff, ea_valid_ff, imm_valid_ff, mul_valid_ff;
  logic [1:0]  n, length_ff;
  logic [2:0]  mode_ff;
  logic [7:0]  fetch_byte, acc_in, idx_in, opcode_ff, imm_ff, mul_acc_ff, mul_idx_ff;
  logic [15:0] pc_in, ea_ff, pc_next_ff;
  logic [23:0] bytes;
  int          bad_count, n_compared, cyc, s;
  row_t rows[13] = '{
    '{8'h4c, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 3'h0, 2'h1, 16'h0000, 16'h1001},
    '{8'h42, 8'h00, 8'h00, 8'hff, 8'hff, 1'b0, 3'h0, 2'h1, 16'h0000, 16'h1001},
    '{8'h9d, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 3'h0, 2'h1, 16'h0000, 16'h1001},
    '{8'ha6, 8'h5a, 8'h00, 8'h00, 8'h00, 1'b0, 3'h1, 2'h2, 16'h0000, 16'h1002},
    '{8'hb7, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0, 3'h2, 2'h2, 16'h0080, 16'h1002},
    '{8'h11, 8'hff, 8'h00, 8'h00, 8'h00, 1'b0, 3'h2, 2'h2, 16'h00ff, 16'h1002},
    '{8'hc6, 8'h12, 8'h34, 8'h00, 8'h00, 1'b0, 3'h3, 2'h3, 16'h1234, 16'h1003},
    '{8'hf6, 8'h00, 8'h00, 8'h00, 8'hff, 1'b0, 3'h4, 2'h1, 16'h00ff, 16'h1001},
    '{8'he6, 8'hff, 8'h00, 8'h00, 8'hff, 1'b0, 3'h5, 2'h2, 16'h01fe, 16'h1002},
    '{8'hd6, 8'hff, 8'hff, 8'h00, 8'h02, 1'b0, 3'h6, 2'h3, 16'h0001, 16'h1003},
    '{8'h20, 8'h80, 8'h00, 8'h00, 8'h00, 1'b1, 3'h7, 2'h2, 16'h0000, 16'h0f82},
    '{8'h26, 8'h7f, 8'h00, 8'h00, 8'h00, 1'b1, 3'h7, 2'h2, 16'h0000, 16'h1081},
    '{8'h27, 8'h80, 8'h00, 8'h00, 8'h00, 1'b0, 3'h7, 2'h2, 16'h0000, 16'h1002}};

  addressing_mode_ea_unit #(.ADDR_W(16)) addressing_mode_ea_unit_inst (.clk(clk), .arst_n(arst_n),
    .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .pc_in(pc_in), .acc_in(acc_in), .idx_in(idx_in),
    .cond_true(cond_true), .dec_valid_ff(dec_valid_ff), .opcode_ff(opcode_ff), .mode_ff(mode_ff),
    .length_ff(length_ff), .ea_valid_ff(ea_valid_ff), .ea_ff(ea_ff), .imm_valid_ff(imm_valid_ff),
    .imm_ff(imm_ff), .pc_next_ff(pc_next_ff), .mul_valid_ff(mul_valid_ff), .mul_acc_ff(mul_acc_ff),
    .mul_idx_ff(mul_idx_ff), .busy(busy));
  fetch_feeder fetch_feeder_inst (.clk(clk), .arst_n(arst_n), .go(go), .stall(stall), .n(n), .bytes(bytes),
    .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));

  // ==========================================================
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Backstop only; wait_dec already gives up on a lost answer after 12 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [23:0] b, input logic [1:0] nn, input logic st);
    {bytes, n, stall, go} = {b, nn, st, 1'b1};
    @(posedge clk);
    #1 go = 1'b0;
  endtask

  // Bounded wait for the one-cycle completion pulse
  task automatic wait_dec();
    int k;
    k = 0;
    while (dec_valid_ff !== 1'b1 && k < 12)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk(dec_valid_ff, 1'b1);
  endtask

  task automatic issue(input row_t r, input logic st);
    {acc_in, idx_in, cond_true} = {r.a, r.x, r.c};
    send({r.op, r.b1, r.b2}, r.ln, st);
    wait_dec();
    chk(mode_ff, r.md);
    chk({imm_valid_ff, mul_valid_ff, opcode_ff}, {r.md == 3'h1, r.op == 8'h42, r.op});
    chk(length_ff, r.ln);
    chk(ea_ff, r.ea);
    chk(pc_next_ff, r.pn);
    chk(ea_valid_ff, r.md inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6});
    if (r.md == 3'h1) chk({imm_valid_ff, imm_ff}, {1'b1, r.b1});
    if (r.op == 8'h42) chk({mul_valid_ff, mul_idx_ff, mul_acc_ff}, {1'b1, {8'h00, r.a} * {8'h00, r.x}});
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {arst_n, go, stall, cond_true, n, bytes} = '0;
    {pc_in, acc_in, idx_in} = {16'h1000, 8'h00, 8'h00};
    repeat (4) @(posedge clk);
    #1 chk({dec_valid_ff, busy, mode_ff, length_ff}, {2'b00, 3'h0, 2'h1});
    arst_n = 1'b1;
    // Table rows, once streamed and once with idle gaps
    for (s = 0; s < 2; s++)
      foreach (rows[i]) issue(rows[i], s[0]);
    // Back-to-back: one-byte inherent then indexed
    // Opcode at fffe, just below the top of memory, so the next address is ffff
    idx_in = 8'h33;
    pc_in = 16'hfffe;
    send({8'h4c, 8'hf6, 8'h00}, 2'h2, 1'b0);
    wait_dec();
    chk({mode_ff, pc_next_ff}, {3'h0, 16'hffff});
    @(posedge clk);
    #1 chk({dec_valid_ff, mode_ff, ea_ff, pc_next_ff}, {1'b1, 3'h4, 16'h0033, 16'hffff});
    pc_in = 16'h1000;
    // Reset in mid-instruction, then recovery
    send({8'hc6, 8'h12, 8'h34}, 2'h3, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk(busy, 1'b1);
    arst_n = 1'b0;
    #1 chk({busy, dec_valid_ff}, 2'b00);
    @(posedge clk);
    #1 arst_n = 1'b1;
    issue(rows[6], 1'b0);
    report_and_stop();
  end
endmodule

/* test/fetch_feeder.sv */
// Purpose: Instruction fetch side, one byte per cycle
// Assumes: go is a one-cycle request with bytes high-first
// Notes:   Idle bus inverts the byte each cycle, so every second idle cycle repeats the last byte
`timescale 1ns/10ps
module fetch_feeder
(
  input  logic        clk,
  input  logic        arst_n,
  input  logic        go,
  input  logic        stall,
  input  logic [1:0]  n,
  input  logic [23:0] bytes,
  output logic        fetch_valid,
  output logic [7:0]  fetch_byte
);
  // ==========================================================
  // Byte sequencer
  logic [1:0]  left_ff;
  logic [23:0] sh_ff;
  logic        gap_ff;

  // Stall option inserts one idle cycle between bytes
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      {left_ff, sh_ff, gap_ff, fetch_valid} <= '0;
      fetch_byte <= 8'h00;
    end
    else if (go)
    begin
      {fetch_valid, fetch_byte} <= {1'b1, bytes[23:16]};
      {sh_ff, left_ff, gap_ff} <= {bytes[15:0], 8'h00, n - 2'h1, stall};
    end
    else if (left_ff != 2'h0 && !(gap_ff && fetch_valid))
    begin
      {fetch_valid, fetch_byte} <= {1'b1, sh_ff[23:16]};
      {sh_ff, left_ff} <= {sh_ff[15:0], 8'h00, left_ff - 2'h1};
    end
    else
      {fetch_valid, fetch_byte} <= {1'b0, ~fetch_byte};
endmodule
